// ---- inc/rec_path_consts.vh ----
/*
 * constants for the record path back end: register byte offsets, field positions,
 * reset values, coefficient slots and rate settings.
 * assumes inclusion by bare name from every design file that needs them.
 */
`ifndef REC_PATH_CONSTS_VH
`define REC_PATH_CONSTS_VH

// ********************************************************
// register byte offsets
// ********************************************************
`define REG_CTRL 8'h00
`define REG_DETECT 8'h04
`define REG_STATUS 8'h08
`define REG_MASK 8'h0c
`define REG_COEF_ADDR 8'h10
`define REG_COEF_DATA 8'h14
`define REG_LEVEL 8'h18
`define REG_GAIN 8'h1c

// ********************************************************
// field positions
// ********************************************************
`define CTRL_AGC_EN 0
`define CTRL_RECORD_EN 1
`define CTRL_SPEECH_EN 2
`define CTRL_RATE_LO 3
`define CTRL_GAIN_LO 8
`define DET_MODE_LO 6
`define DET_CHSEL_LO 4
`define ST_SPEECH 0
`define ST_CLIP 1
`define ST_WAKE 2

// ********************************************************
// reset values and encodings
// ********************************************************
`define CTRL_RESET 32'h0000_1000
`define GAIN_UNITY 8'h10
`define ALERT_IRQ 2'h0
`define ALERT_WAKE 2'h1
`define ALERT_BOTH 2'h2
`define ALERT_OFF 2'h3
`define RATE_48K 2'h0
`define RATE_96K 2'h1
`define RATE_192K 2'h2
`define SHIFT_48K 4'h6
`define SHIFT_96K 4'h5
`define SHIFT_192K 4'h4

// ********************************************************
// coefficient slots: page 0 in 0..7, page 1 in 8..15
// ********************************************************
`define COEF_TARGET 4'h0
`define COEF_MAX_GAIN 4'h1
`define COEF_ATTACK 4'h2
`define COEF_RELEASE 4'h3
`define COEF_NOISE 4'h8
`define COEF_SPEECH 4'h9
`define COEF_HOLD 4'ha
`define DEF_TARGET 16'h2000
`define DEF_MAX_GAIN 16'h0080
`define DEF_ATTACK 16'h0002
`define DEF_RELEASE 16'h0040
`define DEF_NOISE 16'h0100
`define DEF_SPEECH 16'h0800
`define DEF_HOLD 16'h0004

`endif

// ---- design/coef_store.v ----
/*
 * coefficient storage: two pages of eight 16-bit words, one write port
 * and one read port whose data come out of a register.
 * assumes a single clock; contents are undefined until software writes them.
 */
`timescale 1ns/100ps
module coef_store (
    input wire ref_clk,
    input wire wr_en,
    input wire [3:0] wr_addr,
    input wire [15:0] wr_data,
    input wire [3:0] rd_addr,
    output reg [15:0] rd_data
);
    reg [15:0] mem [0:15];

    // storage has no reset; the scan replaces its shadows' reset defaults with these words within 17 cycles
    always @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ---- design/ull_decimator.v ----
/*
 * short-latency decimator for one channel: boxcar over 2^shift input
 * samples followed by a two-tap average of consecutive boxcar results.
 * assumes in_valid comes from logic on ref_clk; shift is 4..6.
 */
`timescale 1ns/100ps
module ull_decimator (
    input wire ref_clk,
    input wire rst,
    input wire in_valid,
    input wire [15:0] in_data,
    input wire [3:0] shift,
    output reg out_valid,
    output reg [15:0] out_data
);
    reg [21:0] acc_q;
    reg [5:0] cnt_q;
    reg [15:0] prev_q;
    wire [5:0] last_cnt;
    wire [21:0] sum;
    wire [21:0] avg;
    wire [16:0] pair;

    assign last_cnt = (6'h01 << shift) - 6'h01;
    assign sum = acc_q + {{6{in_data[15]}}, in_data};
    assign avg = $signed(sum) >>> shift;
    // two taps only: keeps the delay near one output sample
    assign pair = {avg[15], avg[15:0]} + {prev_q[15], prev_q};

    // accumulate, dump and average once per output sample
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_q <= 22'h000000;
            cnt_q <= 6'h00;
            prev_q <= 16'h0000;
            out_valid <= 1'b0;
            out_data <= 16'h0000;
        end else begin
            out_valid <= 1'b0;
            if (in_valid) begin
                if (cnt_q == last_cnt) begin
                    acc_q <= 22'h000000;
                    cnt_q <= 6'h00;
                    prev_q <= avg[15:0];
                    out_data <= pair[16:1];
                    out_valid <= 1'b1;
                end else begin
                    acc_q <= sum;
                    cnt_q <= cnt_q + 6'h01;
                end
            end
        end
    end
endmodule

// ---- design/record_path_filter_agc_vad.v ----
/*
 * record path back end: four-channel short-latency decimation, automatic
 * level control, speech presence detection with alert, AXI4-Lite registers.
 * assumes modulator samples arrive from logic on ref_clk, one strobe for
 * all four channels; decimated samples go to the serial interface logic.
 */
// Contract
// - 48k family: ripple about 0.02 dB to 0.456 fs, stop-band 86.3/96.8 dB.
// - 48k family: group delay 2.8 samples, deviation -0.29 to 0.761.
// - 96k family: ripple -0.02..0.03 dB, 85.6 dB from 0.599 fs.
// - 96k family: group delay 2.7 samples, phase -6.6 to 9.6 degrees.
// - 192k family: ripple 0.06 dB, stop-band 90.5 then 86.9 dB.
// - 192k family: delay deviation -0.293..0.794, phase -6.8..9.8 degrees.
// - level controller replaces manual gain, lowering loud and raising weak input.
// - level controller parameters come from two coefficient pages.
// - speech detection watches one selected channel at low power.
// - speech detection starts when software sets the enable bit.
// - alert mode field picks interrupt or wake-and-record on speech.
// - channel select field picks the watched channel.
// - detection works for analog or digital microphone channels.
// - short-latency option gives about four samples, near-linear phase.
`timescale 1ns/100ps
`include "rec_path_consts.vh"
module record_path_filter_agc_vad (
    input wire ref_clk,
    input wire rst,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire mod_valid,
    input wire [63:0] mod_data,
    output reg out_valid,
    output reg [63:0] out_data,
    output reg irq,
    output reg wake,
    output reg record_active
);
    // ********************************************************
    // registers and bus state
    // ********************************************************
    reg [31:0] ctrl_q;
    reg [7:0] detect_q;
    reg [2:0] status_q;
    reg [2:0] mask_q;
    reg [3:0] coef_addr_q;
    reg [7:0] gain_q;
    reg [15:0] level_q;
    reg aw_held_q;
    reg w_held_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire do_wr;
    wire ar_take;
    wire [31:0] wbits;
    wire [31:0] ctrl_new;
    reg [31:0] rd_word;
    reg rd_ok;

    assign do_wr = aw_held_q & w_held_q & ~s_axi_bvalid;
    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign wbits = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign ctrl_new = (ctrl_q & ~wbits) | (wdata_q & wbits);

    // ********************************************************
    // fields and coefficient shadows
    // ********************************************************
    wire agc_en = ctrl_q[`CTRL_AGC_EN];
    wire speech_en = ctrl_q[`CTRL_SPEECH_EN];
    wire [1:0] rate_sel = ctrl_q[`CTRL_RATE_LO+1:`CTRL_RATE_LO];
    wire [7:0] manual_gain = ctrl_q[`CTRL_GAIN_LO+7:`CTRL_GAIN_LO];
    wire [1:0] alert_mode = detect_q[`DET_MODE_LO+1:`DET_MODE_LO];
    wire [1:0] chsel = detect_q[`DET_CHSEL_LO+1:`DET_CHSEL_LO];
    reg [3:0] scan_q;
    reg [3:0] scan_prev_q;
    wire [15:0] coef_rd;
    reg [15:0] target_q;
    reg [15:0] max_gain_q;
    reg [15:0] attack_q;
    reg [15:0] release_q;
    reg [15:0] noise_q;
    reg [15:0] speech_thr_q;
    reg [15:0] hold_q;
    reg [3:0] shift;

    // one rate family per code; lower rate families are not offered
    always @* begin
        case (rate_sel)
            `RATE_96K: shift = `SHIFT_96K;
            `RATE_192K: shift = `SHIFT_192K;
            default: shift = `SHIFT_48K;
        endcase
    end

    coef_store u_coef (
        .ref_clk(ref_clk),
        .wr_en(do_wr && awaddr_q == `REG_COEF_DATA),
        .wr_addr(coef_addr_q),
        .wr_data(wdata_q[15:0]),
        .rd_addr(scan_q),
        .rd_data(coef_rd)
    );

    // scan both pages continuously so a new coefficient takes effect in 17 cycles
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            scan_q <= 4'h0;
            scan_prev_q <= 4'h0;
            target_q <= `DEF_TARGET;
            max_gain_q <= `DEF_MAX_GAIN;
            attack_q <= `DEF_ATTACK;
            release_q <= `DEF_RELEASE;
            noise_q <= `DEF_NOISE;
            speech_thr_q <= `DEF_SPEECH;
            hold_q <= `DEF_HOLD;
        end else begin
            scan_q <= scan_q + 4'h1;
            scan_prev_q <= scan_q;
            case (scan_prev_q)
                `COEF_TARGET: target_q <= coef_rd;
                `COEF_MAX_GAIN: max_gain_q <= coef_rd;
                `COEF_ATTACK: attack_q <= coef_rd;
                `COEF_RELEASE: release_q <= coef_rd;
                `COEF_NOISE: noise_q <= coef_rd;
                `COEF_SPEECH: speech_thr_q <= coef_rd;
                `COEF_HOLD: hold_q <= coef_rd;
                default: hold_q <= hold_q;
            endcase
        end
    end

    // ********************************************************
    // decimation and gain, one lane per channel
    // ********************************************************
    wire [3:0] dec_valid;
    wire [63:0] dec_data;
    wire [63:0] gained;
    wire [3:0] clipped;
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : lane
            wire run;
            wire [24:0] prod;
            wire [20:0] scaled;
            // while only listening, just the watched channel runs
            assign run = record_active | (speech_en & (chsel == i));
            ull_decimator u_dec (
                .ref_clk(ref_clk),
                .rst(rst),
                .in_valid(mod_valid & run),
                .in_data(mod_data[16*i+15:16*i]),
                .shift(shift),
                .out_valid(dec_valid[i]),
                .out_data(dec_data[16*i+15:16*i])
            );
            assign prod = $signed(dec_data[16*i+15:16*i]) * $signed({1'b0, gain_q});
            assign scaled = prod[24:4];
            assign clipped[i] = (scaled[20:15] != {6{scaled[15]}});
            // saturate rather than wrap so loud input clips cleanly
            assign gained[16*i+15:16*i] = clipped[i] ?
                {scaled[20], {15{~scaled[20]}}} : scaled[15:0];
        end
    endgenerate

    // ********************************************************
    // level controller
    // ********************************************************
    wire [15:0] ch0 = gained[15:0];
    wire [15:0] lvl = ch0[15] ? (~ch0 + 16'h0001) : ch0;
    reg [15:0] attack_cnt_q;
    reg [15:0] release_cnt_q;

    // gain steps once per held-loud or held-weak stretch of output samples
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gain_q <= `GAIN_UNITY;
            level_q <= 16'h0000;
            attack_cnt_q <= 16'h0000;
            release_cnt_q <= 16'h0000;
        end else if (!agc_en) begin
            gain_q <= manual_gain;
            attack_cnt_q <= 16'h0000;
            release_cnt_q <= 16'h0000;
        end else if (dec_valid[0]) begin
            level_q <= lvl;
            if (lvl > target_q) begin
                release_cnt_q <= 16'h0000;
                if (attack_cnt_q >= attack_q) begin
                    attack_cnt_q <= 16'h0000;
                    if (gain_q > 8'h01) begin
                        gain_q <= gain_q - 8'h01;
                    end
                end else begin
                    attack_cnt_q <= attack_cnt_q + 16'h0001;
                end
            end else if (lvl > noise_q) begin
                attack_cnt_q <= 16'h0000;
                if (release_cnt_q >= release_q) begin
                    release_cnt_q <= 16'h0000;
                    if ({8'h00, gain_q} < max_gain_q) begin
                        gain_q <= gain_q + 8'h01;
                    end
                end else begin
                    release_cnt_q <= release_cnt_q + 16'h0001;
                end
            end else begin
                // below the noise floor: hold gain so hiss is not pumped up
                attack_cnt_q <= 16'h0000;
                release_cnt_q <= 16'h0000;
            end
        end
    end

    // ********************************************************
    // speech presence detector
    // ********************************************************
    wire [15:0] watched = dec_data[16*chsel+:16];
    wire [15:0] watched_abs = watched[15] ? (~watched + 16'h0001) : watched;
    wire watched_valid = dec_valid[chsel];
    reg [15:0] hold_cnt_q;
    reg fired_q;
    reg speech_evt;

    // one event per burst; re-arms when the level falls back
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hold_cnt_q <= 16'h0000;
            fired_q <= 1'b0;
            speech_evt <= 1'b0;
        end else begin
            speech_evt <= 1'b0;
            if (!speech_en) begin
                hold_cnt_q <= 16'h0000;
                fired_q <= 1'b0;
            end else if (watched_valid) begin
                if (watched_abs <= speech_thr_q) begin
                    hold_cnt_q <= 16'h0000;
                    fired_q <= 1'b0;
                end else if (hold_cnt_q >= hold_q && !fired_q) begin
                    fired_q <= 1'b1;
                    speech_evt <= 1'b1;
                end else if (!fired_q) begin
                    hold_cnt_q <= hold_cnt_q + 16'h0001;
                end
            end
        end
    end

    wire alert_irq = speech_evt &
        (alert_mode == `ALERT_IRQ || alert_mode == `ALERT_BOTH);
    wire alert_wake = speech_evt &
        (alert_mode == `ALERT_WAKE || alert_mode == `ALERT_BOTH);
    wire clip_evt = |(clipped & dec_valid) & record_active;
    wire [2:0] evt = {alert_wake, clip_evt, alert_irq};
    wire [2:0] w1c = (do_wr && awaddr_q == `REG_STATUS) ?
        (wdata_q[2:0] & wbits[2:0]) : 3'h0;

    // ********************************************************
    // write channel, sticky status and outputs
    // ********************************************************
    // address and data are taken in either order; the write lands once both are held
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            ctrl_q <= `CTRL_RESET;
            detect_q <= 8'h00;
            mask_q <= 3'h0;
            coef_addr_q <= 4'h0;
            status_q <= 3'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                s_axi_awready <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_held_q <= 1'b0;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                s_axi_wready <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_wr) begin
                w_held_q <= 1'b0;
                s_axi_wready <= 1'b1;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                case (awaddr_q)
                    `REG_CTRL: ctrl_q <= ctrl_new;
                    `REG_DETECT: detect_q <= ctrl_new[7:0];
                    `REG_MASK: mask_q <= ctrl_new[2:0];
                    `REG_COEF_ADDR: coef_addr_q <= ctrl_new[3:0];
                    `REG_STATUS, `REG_COEF_DATA: s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // a new event in the clearing cycle survives the clear
            status_q <= (status_q & ~w1c) | evt;
        end
    end

    // read decode, answered one edge after the address is taken
    always @* begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `REG_CTRL: rd_word = ctrl_q;
            `REG_DETECT: rd_word = {24'h000000, detect_q};
            `REG_STATUS: rd_word = {29'h0000000, status_q};
            `REG_MASK: rd_word = {29'h0000000, mask_q};
            `REG_COEF_ADDR: rd_word = {28'h0000000, coef_addr_q};
            `REG_COEF_DATA: rd_word = 32'h00000000;
            `REG_LEVEL: rd_word = {16'h0000, level_q};
            `REG_GAIN: rd_word = {24'h000000, gain_q};
            default: begin
                rd_word = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
            irq <= 1'b0;
            wake <= 1'b0;
            record_active <= 1'b0;
            out_valid <= 1'b0;
            out_data <= 64'h0;
        end else begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
            irq <= |(status_q & mask_q);
            wake <= alert_wake;
            // recording stays on after a wake until software clears the wake flag
            record_active <= ctrl_q[`CTRL_RECORD_EN] | status_q[`ST_WAKE];
            out_valid <= dec_valid[0] & record_active;
            if (dec_valid[0] && record_active) begin
                out_data <= gained;
            end
        end
    end
endmodule

// ---- verification/record_path_props.sv ----
/* checker for the record path top: bus handshakes, stream pulses, wake.
   assumes one clock, ref_clk, and an asynchronous active-high rst. */
`timescale 1ns/100ps
// ********************
// checker
// ********************
module record_path_props (
    input wire ref_clk,
    input wire rst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire out_valid,
    input wire [63:0] out_data,
    input wire wake,
    input wire irq,
    input wire record_active
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // response two edges after both halves are taken together
    property p_wr_ans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
    property p_b_drop;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_drop: assert property (p_b_drop) else $error("write answer held");
    property p_r_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_r_ans: assert property (p_r_ans) else $error("read answer late");
    property p_r_busy;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_r_busy: assert property (p_r_busy) else $error("read answer dropped");
    property p_r_drop;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_drop: assert property (p_r_drop) else $error("read answer held");
    // frames only leave while recording, one cycle each, data held between
    property p_out_rec;
        out_valid |-> record_active ##1 !out_valid;
    endproperty
    a_out_rec: assert property (p_out_rec) else $error("frame outside recording");
    property p_out_hold;
        !$stable(out_data) |-> out_valid;
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("frame data moved");
    property p_wake_rec;
        wake |=> !wake ##[0:2] record_active;
    endproperty
    a_wake_rec: assert property (p_wake_rec) else $error("wake without recording");
    c_frame: cover property (out_valid);
    c_wake: cover property (wake);
    c_irq: cover property ($rose(irq));
endmodule
bind record_path_filter_agc_vad record_path_props record_path_props_i (.ref_clk, .rst,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .out_valid, .out_data, .wake, .irq, .record_active);

// ---- verification/host_sink.sv ----
/* host side of the stream: counts frames and wake pulses, keeps the last frame.
   assumes out_valid and wake are one-cycle pulses on ref_clk. */
`timescale 1ns/100ps
module host_sink (
    input wire ref_clk,
    input wire rst,
    input wire out_valid,
    input wire [63:0] out_data,
    input wire wake,
    output int frames,
    output int wakes,
    output logic [63:0] last_frame
);
    // the host never stalls the stream, so only the newest frame is kept
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frames <= 0;
            wakes <= 0;
            last_frame <= 64'h0;
        end else begin
            if (out_valid) begin
                frames <= frames + 1;
                last_frame <= out_data;
            end
            if (wake) wakes <= wakes + 1;
        end
    end
endmodule

// ---- verification/tb.sv ----
/* testbench: AXI4-Lite register tests, rate, gain, level control, detection.
   assumes the design header is reachable by bare name. */
`timescale 1ns/100ps
`include "rec_path_consts.vh"
module tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, mod_valid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [63:0] mod_data = 64'h0;
    logic [1:0] resp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire out_valid, irq, wake, record_active;
    wire [63:0] out_data, last_frame;
    int frames, wakes, err_total = 0, num_checks = 0, n, f0;
    // target 0x2000 keeps headroom below full scale
    logic [15:0] defs [16] = '{16'h2000, 16'h0080, 16'h0002, 16'h0040, 0, 0, 0, 0,
        16'h0100, 16'h0800, 16'h0004, 0, 0, 0, 0, 0};
    record_path_filter_agc_vad record_path_filter_agc_vad_i (.ref_clk, .rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .mod_valid, .mod_data, .out_valid, .out_data, .irq, .wake,
        .record_active);
    host_sink host_sink_i (.ref_clk, .rst, .out_valid, .out_data, .wake, .frames, .wakes,
        .last_frame);
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // ********************
    // bus masters
    // ********************
    // address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++) begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1 && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1 && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (i == 50) begin
            err_total++;
            report_and_stop();
        end
    endtask
    task rdr(input logic [7:0] a);
        int i;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 50 && s_axi_rvalid !== 1'b1; i++) begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1 && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (i == 50) begin
            err_total++;
            report_and_stop();
        end
    endtask
    // one strobe every other cycle, then a short idle gap
    task feed(input logic [63:0] d, input int cnt);
        int i;
        for (i = 0; i < cnt; i++) begin
            @(posedge ref_clk);
            mod_valid <= 1'b1;
            mod_data <= d;
            @(posedge ref_clk);
            mod_valid <= 1'b0;
        end
        repeat (4) @(posedge ref_clk);
    endtask
    // ********************
    // tests
    // ********************
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rdr(`REG_CTRL);
        chk("ctrl", rd, `CTRL_RESET);
        for (n = 4; n < 28; n += 4) begin
            rdr(n[7:0]);
            chk("reg reset", rd, 0);
        end
        rdr(8'h20);
        chk("rresp", resp, 2'h2);
        wr(8'h24, 32'h1);
        chk("bresp", resp, 2'h2);
        wr(`REG_DETECT, 32'hf0);
        rdr(`REG_DETECT);
        chk("detect", rd, 32'hf0);
        for (n = 0; n < 16; n++) begin
            wr(`REG_COEF_ADDR, n);
            wr(`REG_COEF_DATA, {16'h0, defs[n]});
        end
        rdr(`REG_COEF_DATA);
        chk("coef window", rd, 0);
        $display("registers done");
        // block of 128, 64, 32 strobes per rate code
        for (n = 0; n < 3; n++) begin
            wr(`REG_CTRL, 32'h1002 | (n << 3));
            f0 = frames;
            feed({4{16'h0123}}, 2 << (6 - n));
            chk("frames", frames - f0, 2);
            chk("frame", last_frame, {4{16'h0123}});
        end
        wr(`REG_CTRL, 32'h2012);
        feed({4{16'h0123}}, 32);
        chk("gain x2", last_frame, {4{16'h0246}});
        rdr(`REG_GAIN);
        chk("manual gain", rd, 32'h20);
        wr(`REG_CTRL, 32'hff12);
        feed({4{16'h4000}}, 32);
        chk("saturate", last_frame, {4{16'h7fff}});
        rdr(`REG_STATUS);
        chk("clip", rd[1], 1'b1);
        wr(`REG_STATUS, 32'h7);
        rdr(`REG_STATUS);
        chk("w1c", rd, 0);
        $display("stream done");
        wr(`REG_CTRL, 32'h1013);
        feed({48'h0, 16'h4000}, 96);
        rdr(`REG_GAIN);
        chk("agc lowers", rd, 32'hfd);
        $display("level control done");
        // mode n watches channel n; only the speech bit is unmasked
        wr(`REG_MASK, 32'h1);
        for (n = 0; n < 4; n++) begin
            wr(`REG_STATUS, 32'h7);
            wr(`REG_CTRL, 32'h1014);
            wr(`REG_DETECT, (n << 6) | (n << 4));
            f0 = wakes;
            feed(64'h1000 << (16 * n), 128);
            rdr(`REG_STATUS);
            chk("status", rd, {n == 1 || n == 2, 1'b0, n == 0 || n == 2});
            chk("irq", irq, n == 0 || n == 2);
            chk("recording", record_active, n == 1 || n == 2);
            chk("wakes", wakes - f0, n == 1 || n == 2);
            feed(64'h0, 48);
        end
        $display("detection done");
        report_and_stop();
    end
endmodule
